// file: rtl/rrlc_top.sv
// Ratiometric reference ladder control with APB register access
//
// Function
// RL1: Ladder enabled only while enable bit set
// RL2: Five-bit level code selects 32 levels
// RL3: Enabled level is lower plus scaled span
// RL4: Disabled, side one, all ones: upper source
// RL5: Disabled, side zero, all zeros: lower source
// RL6: Side select disconnects one ladder end
// RL7: Pin drive routes level, kills digital pin
// RL8: Routed pin reads back as zero
// RL9: Two-bit upper source select, code three reserved
// RL10: Lower select picks external or ground
// RL11: Wake from sleep keeps control register
// RL12: Reset disables ladder, pin, level code
// RL13: Unimplemented register bits read zero
// RL14: Software disables reference before sleep
// RL15: Outputs follow one cycle after write
module rrlc_top
   import rrlc_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Ladder control
   output logic                   ladder_enable,
   output logic                   low_power_side_select,
   output logic [1:0]             upper_source_select,
   output logic                   lower_source_select,
   output logic [4:0]             level_code,
   output logic                   upper_end_connect,
   output logic                   lower_end_connect,
   output logic                   upper_src_supply,
   output logic                   upper_src_ext,
   output logic                   upper_src_fixed,
   output logic                   lower_src_ext,
   output logic                   lower_src_ground,
   // Selected level as a ladder tap, 32 means upper source
   output logic [5:0]             level_tap,
   output logic                   level_tap_valid,
   // Port logic side of the output pin
   input  wire logic              port_dout,
   input  wire logic              port_oe_n,
   output logic                   port_din,
   // Output pin
   input  wire logic              level_out_pin_in,
   output logic                   level_out_pin_out,
   output logic                   level_out_pin_oe_n,
   output logic                   level_out_pin_analog,
   output logic                   level_out_pin_detector_en
);

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [7:0]  ctrl_main;
      logic [7:0]  ctrl_level;
      logic [31:0] rdata;
      logic        rerr;
      logic        en;
      logic        lps;
      logic [1:0]  uss;
      logic        lss;
      logic [4:0]  code;
      logic        pin_analog;
      logic        up_conn;
      logic        lo_conn;
      logic [2:0]  up_onehot;
      logic        lo_ext;
      logic [5:0]  tap;
      logic        tap_valid;
      logic        rsvd_sel;
   } rrlc_state_s;

   rrlc_state_s st;
   rrlc_state_s next_st;

   rrlc_pin_if pif ();

   ////////////////////////////////////////////////////////////////////////
   // Functions

   // Register index of a bus address
   function automatic logic [1:0] rrlc_decode(
      input logic [ADDR_W-1:0] addr
   );
      logic [1:0] idx;
      idx = RRLC_IDX_NONE;
      if (addr == ADDR_W'(RRLC_OFF_MAIN)) begin
         idx = RRLC_IDX_MAIN;
      end else if (addr == ADDR_W'(RRLC_OFF_LEVEL)) begin
         idx = RRLC_IDX_LEVEL;
      end else if (addr == ADDR_W'(RRLC_OFF_STATUS)) begin
         idx = RRLC_IDX_STATUS;
      end
      return idx;
   endfunction : rrlc_decode

   // One-hot upper source, none for the reserved code
   function automatic logic [2:0] rrlc_upper_onehot(
      input logic [1:0] sel
   );
      logic [2:0] oh;
      oh = 3'h0;
      case (sel)
         RRLC_US_SUPPLY: begin
            oh = 3'h1; // RL9
         end
         RRLC_US_EXT: begin
            oh = 3'h2; // RL9
         end
         RRLC_US_FIXED: begin
            oh = 3'h4; // RL9
         end
         default: begin
            oh = 3'h0; // RL9
         end
      endcase
      return oh;
   endfunction : rrlc_upper_onehot

   ////////////////////////////////////////////////////////////////////////
   // Bus phase decode

   logic       setup_ph;
   logic       access_ph;
   logic [1:0] bus_idx;
   logic [7:0] main_wr;
   logic [7:0] level_wr;
   logic [31:0] status_rd;

   assign setup_ph  = psel & ~penable;
   assign access_ph = psel & penable;
   assign bus_idx   = rrlc_decode(paddr);
   assign main_wr   = pwdata[7:0] & RRLC_MAIN_MASK; // RL13
   assign level_wr  = pwdata[7:0] & RRLC_LEVEL_MASK; // RL13

   always_comb begin
      status_rd = 32'h0000_0000;
      status_rd[RRLC_ST_VALID]  = st.tap_valid;
      status_rd[RRLC_ST_UPCONN] = st.up_conn;
      status_rd[RRLC_ST_LOCONN] = st.lo_conn;
      status_rd[RRLC_ST_RSVD]   = st.rsvd_sel;
      status_rd[RRLC_ST_TAP_LO +: RRLC_TAP_W] = st.tap;
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      next_st = st;

      // Read data is prepared in the setup cycle
      if (setup_ph) begin
         next_st.rdata = 32'h0000_0000;
         next_st.rerr  = (bus_idx == RRLC_IDX_NONE);
         if (!pwrite) begin
            if (bus_idx == RRLC_IDX_MAIN) begin
               next_st.rdata = {24'h00_0000, st.ctrl_main}; // RL13
            end else if (bus_idx == RRLC_IDX_LEVEL) begin
               next_st.rdata = {24'h00_0000, st.ctrl_level}; // RL13
            end else if (bus_idx == RRLC_IDX_STATUS) begin
               next_st.rdata = status_rd;
            end
         end
      end

      // Writes land on the access edge; status is read-only
      if (access_ph && pwrite && pstrb[0]) begin // RL15
         if (bus_idx == RRLC_IDX_MAIN) begin
            next_st.ctrl_main = main_wr;
         end else if (bus_idx == RRLC_IDX_LEVEL) begin
            next_st.ctrl_level = level_wr; // RL2
         end
      end

      // Control copies follow the registers one edge later
      next_st.en   = st.ctrl_main[RRLC_BIT_EN]; // RL1
      next_st.lps  = st.ctrl_main[RRLC_BIT_LPS];
      next_st.uss  = st.ctrl_main[RRLC_BIT_USS_HI:RRLC_BIT_USS_LO];
      next_st.lss  = st.ctrl_main[RRLC_BIT_LSS]; // RL10
      next_st.code = st.ctrl_level[RRLC_CODE_W-1:0]; // RL2
      next_st.pin_analog = st.ctrl_main[RRLC_BIT_PIN]; // RL7

      // Ladder ends: both while enabled, else one per side select
      next_st.up_conn = st.ctrl_main[RRLC_BIT_EN]
                      | st.ctrl_main[RRLC_BIT_LPS]; // RL6
      next_st.lo_conn = st.ctrl_main[RRLC_BIT_EN]
                      | ~st.ctrl_main[RRLC_BIT_LPS]; // RL6

      next_st.up_onehot = rrlc_upper_onehot(
         st.ctrl_main[RRLC_BIT_USS_HI:RRLC_BIT_USS_LO]);
      next_st.rsvd_sel  = (st.ctrl_main[RRLC_BIT_USS_HI:RRLC_BIT_USS_LO]
                           == RRLC_US_RSVD); // RL9
      next_st.lo_ext    = st.ctrl_main[RRLC_BIT_LSS]; // RL10

      // Selected ladder tap
      next_st.tap       = RRLC_TAP_LOWER;
      next_st.tap_valid = 1'b0;
      if (st.ctrl_main[RRLC_BIT_EN]) begin
         next_st.tap = {1'b0, st.ctrl_level[RRLC_CODE_W-1:0]}; // RL3
         next_st.tap_valid = 1'b1; // RL3
      end else if (st.ctrl_main[RRLC_BIT_LPS]
                   && st.ctrl_level[RRLC_CODE_W-1:0] == RRLC_CODE_ONES) begin
         next_st.tap = RRLC_TAP_UPPER; // RL4
         next_st.tap_valid = 1'b1; // RL4
      end else if (!st.ctrl_main[RRLC_BIT_LPS]
                   && st.ctrl_level[RRLC_CODE_W-1:0] == RRLC_CODE_ZERO) begin
         next_st.tap = RRLC_TAP_LOWER; // RL5
         next_st.tap_valid = 1'b1; // RL5
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   // Only device reset clears state; wake from sleep has no path here
   always_ff @(posedge pclk or negedge presetn) begin // RL11
      if (!presetn) begin
         st            <= '0; // RL12
         st.ctrl_main  <= RRLC_MAIN_RST; // RL12
         st.ctrl_level <= RRLC_LEVEL_RST; // RL12
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus answer

   assign pready  = 1'b1;
   assign prdata  = st.rdata;
   assign pslverr = access_ph & st.rerr;

   ////////////////////////////////////////////////////////////////////////
   // Ladder outputs

   assign ladder_enable         = st.en; // RL1
   assign low_power_side_select = st.lps;
   assign upper_source_select   = st.uss; // RL9
   assign lower_source_select   = st.lss; // RL10
   assign level_code            = st.code; // RL2
   assign upper_end_connect     = st.up_conn; // RL6
   assign lower_end_connect     = st.lo_conn; // RL6
   assign upper_src_supply      = st.up_onehot[0];
   assign upper_src_fixed       = st.up_onehot[2];
   assign upper_src_ext         = st.up_onehot[1];
   assign lower_src_ext         = st.lo_ext; // RL10
   assign lower_src_ground      = ~st.lo_ext; // RL10
   assign level_tap             = st.tap;
   assign level_tap_valid       = st.tap_valid;

   ////////////////////////////////////////////////////////////////////////
   // Output pin

   assign pif.analog_sel = st.pin_analog; // RL7
   assign pif.core_dout  = port_dout;
   assign pif.core_oe_n  = port_oe_n;
   assign port_din       = pif.core_din;
   assign level_out_pin_analog = st.pin_analog; // RL7

   rrlc_pin_ctrl rrlc_pin_ctrl_inst (
      .pclk            (pclk),
      .presetn         (presetn),
      .pif             (pif.pin),
      .pad_din         (level_out_pin_in),
      .pad_dout        (level_out_pin_out),
      .pad_oe_n        (level_out_pin_oe_n),
      .pad_detector_en (level_out_pin_detector_en)
   );

endmodule : rrlc_top

// file: shared/rrlc_pkg.sv
// Constants shared by the reference ladder control block
package rrlc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] RRLC_OFF_MAIN   = 8'h00;
   localparam logic [7:0] RRLC_OFF_LEVEL  = 8'h04;
   localparam logic [7:0] RRLC_OFF_STATUS = 8'h08;

   ////////////////////////////////////////////////////////////////////////
   // Register index codes returned by the address decoder
   localparam logic [1:0] RRLC_IDX_MAIN   = 2'h0;
   localparam logic [1:0] RRLC_IDX_LEVEL  = 2'h1;
   localparam logic [1:0] RRLC_IDX_STATUS = 2'h2;
   localparam logic [1:0] RRLC_IDX_NONE   = 2'h3;

   ////////////////////////////////////////////////////////////////////////
   // Field positions of reference_control_main
   localparam int RRLC_BIT_EN      = 7;
   localparam int RRLC_BIT_LPS     = 6;
   localparam int RRLC_BIT_PIN     = 5;
   localparam int RRLC_BIT_USS_HI  = 3;
   localparam int RRLC_BIT_USS_LO  = 2;
   localparam int RRLC_BIT_LSS     = 0;

   ////////////////////////////////////////////////////////////////////////
   // Implemented-bit masks and reset values
   localparam logic [7:0] RRLC_MAIN_MASK  = 8'hED;
   localparam logic [7:0] RRLC_LEVEL_MASK = 8'h1F;
   localparam logic [7:0] RRLC_MAIN_RST   = 8'h00;
   localparam logic [7:0] RRLC_LEVEL_RST  = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Level code and ladder tap encoding
   localparam int         RRLC_CODE_W    = 5;
   localparam int         RRLC_TAP_W     = 6;
   localparam logic [4:0] RRLC_CODE_ONES = 5'h1F;
   localparam logic [4:0] RRLC_CODE_ZERO = 5'h00;
   localparam logic [5:0] RRLC_TAP_UPPER = 6'h20;
   localparam logic [5:0] RRLC_TAP_LOWER = 6'h00;

   ////////////////////////////////////////////////////////////////////////
   // Upper source select codes
   localparam logic [1:0] RRLC_US_SUPPLY = 2'h0;
   localparam logic [1:0] RRLC_US_EXT    = 2'h1;
   localparam logic [1:0] RRLC_US_FIXED  = 2'h2;
   localparam logic [1:0] RRLC_US_RSVD   = 2'h3;

   ////////////////////////////////////////////////////////////////////////
   // Status register field positions
   localparam int RRLC_ST_VALID   = 0;
   localparam int RRLC_ST_UPCONN  = 1;
   localparam int RRLC_ST_LOCONN  = 2;
   localparam int RRLC_ST_RSVD    = 3;
   localparam int RRLC_ST_TAP_LO  = 8;

endpackage : rrlc_pkg

// file: shared/rrlc_pin_if.sv
// Carrier between ladder control and the output pin override
interface rrlc_pin_if;
   logic analog_sel;
   logic core_dout;
   logic core_oe_n;
   logic core_din;

   modport ctrl (
      output analog_sel,
      output core_dout,
      output core_oe_n,
      input  core_din
   );

   modport pin (
      input  analog_sel,
      input  core_dout,
      input  core_oe_n,
      output core_din
   );
endinterface : rrlc_pin_if

// file: rtl/rrlc_pin_ctrl.sv
// Output pin override for the reference level
module rrlc_pin_ctrl
   import rrlc_pkg::*;
(
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Control side
   rrlc_pin_if.pin   pif,
   // Pad side
   input  wire logic pad_din,
   output logic      pad_dout,
   output logic      pad_oe_n,
   output logic      pad_detector_en
);

   typedef struct packed {
      logic sync1;
      logic sync2;
   } rrlc_pin_s;

   rrlc_pin_s st;
   rrlc_pin_s next_st;

   ////////////////////////////////////////////////////////////////////////
   // Pad input synchroniser
   always_comb begin
      next_st       = st;
      next_st.sync1 = pad_din;
      next_st.sync2 = st.sync1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Digital driver and detector forced off while the level is routed
   assign pad_dout        = pif.analog_sel ? 1'b0 : pif.core_dout; // RL7
   assign pad_oe_n        = pif.analog_sel | pif.core_oe_n; // RL7
   assign pad_detector_en = ~pif.analog_sel; // RL7
   assign pif.core_din    = pif.analog_sel ? 1'b0 : st.sync2; // RL8

endmodule : rrlc_pin_ctrl

// file: tb/rrlc_top_props.sv
// Concurrent checks on the ports of the reference ladder control
module rrlc_top_props
   import rrlc_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   // Clock, reset and bus
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic [31:0]       prdata,
   // Ladder control
   input wire logic              ladder_enable,
   input wire logic              low_power_side_select,
   input wire logic [1:0]        upper_source_select,
   input wire logic              lower_source_select,
   input wire logic [4:0]        level_code,
   input wire logic              upper_end_connect,
   input wire logic              lower_end_connect,
   input wire logic              upper_src_supply,
   input wire logic              upper_src_ext,
   input wire logic              upper_src_fixed,
   input wire logic              lower_src_ext,
   input wire logic              lower_src_ground,
   input wire logic [5:0]        level_tap,
   input wire logic              level_tap_valid,
   // Pin
   input wire logic              port_din,
   input wire logic              level_out_pin_oe_n,
   input wire logic              level_out_pin_analog,
   input wire logic              level_out_pin_detector_en
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic wr_acc;
   logic wr_main;
   logic wr_level;
   logic rd_main;
   assign wr_acc = psel && penable && pwrite && pstrb[0];
   assign wr_main = wr_acc && paddr == ADDR_W'(RRLC_OFF_MAIN);
   assign wr_level = wr_acc && paddr == ADDR_W'(RRLC_OFF_LEVEL);
   assign rd_main = psel && penable && !pwrite
                    && paddr == ADDR_W'(RRLC_OFF_MAIN);

   ////////////////////////////////////////////////////////////////////////
   chk_enable_follow: assert property (
      wr_main |-> ##2 ladder_enable == $past(pwdata[7], 2))
      else $error("ladder enable did not follow write");
   chk_level_follow: assert property (
      wr_level |-> ##2 level_code == $past(pwdata[4:0], 2))
      else $error("level code did not follow write");
   chk_enabled_tap: assert property (
      ladder_enable |-> level_tap_valid && level_tap == {1'b0, level_code})
      else $error("enabled tap wrong");
   chk_upper_clamp: assert property (
      !ladder_enable && low_power_side_select
      && level_code == RRLC_CODE_ONES
      |-> level_tap_valid && level_tap == RRLC_TAP_UPPER)
      else $error("upper clamp wrong");
   chk_lower_clamp: assert property (
      $past(presetn) && !ladder_enable && !low_power_side_select
      && level_code == RRLC_CODE_ZERO
      |-> level_tap_valid && level_tap == RRLC_TAP_LOWER)
      else $error("lower clamp wrong");
   chk_end_gating: assert property (
      $past(presetn) && !ladder_enable
      |-> upper_end_connect == low_power_side_select
      && lower_end_connect == !low_power_side_select)
      else $error("ladder end gating wrong");
   chk_pin_override: assert property (
      level_out_pin_analog
      |-> level_out_pin_oe_n && !level_out_pin_detector_en)
      else $error("pin not overridden");
   chk_pin_reads_zero: assert property (
      level_out_pin_analog |-> !port_din)
      else $error("pin read not zero");
   chk_upper_onehot: assert property (
      $past(presetn) |-> {upper_src_fixed, upper_src_ext, upper_src_supply}
      == (upper_source_select == RRLC_US_RSVD ? 3'b000
          : 3'b001 << upper_source_select))
      else $error("upper source decode wrong");
   chk_lower_select: assert property (
      {lower_src_ext, lower_src_ground}
      == {lower_source_select, !lower_source_select})
      else $error("lower source decode wrong");
   chk_reset_clear: assert property (
      $rose(presetn)
      |-> !ladder_enable && !level_out_pin_analog && level_code == 5'h00)
      else $error("state not cleared by reset");
   chk_unimpl_zero: assert property (
      rd_main |-> prdata[31:8] == 24'h0 && !prdata[4] && !prdata[1])
      else $error("unimplemented bit read not zero");

   cover property (ladder_enable && level_code == RRLC_CODE_ONES);
   cover property (level_tap_valid && level_tap == RRLC_TAP_UPPER);
   cover property (level_out_pin_analog);
endmodule : rrlc_top_props

bind rrlc_top rrlc_top_props #(.ADDR_W(ADDR_W)) rrlc_top_props_inst (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
   .prdata, .ladder_enable, .low_power_side_select, .upper_source_select,
   .lower_source_select, .level_code, .upper_end_connect,
   .lower_end_connect, .upper_src_supply, .upper_src_ext, .upper_src_fixed,
   .lower_src_ext, .lower_src_ground, .level_tap, .level_tap_valid,
   .port_din, .level_out_pin_oe_n, .level_out_pin_analog,
   .level_out_pin_detector_en
);

// file: tb/rrlc_top_tb.sv
// Self-checking bench for the reference ladder control
module rrlc_top_tb
   import rrlc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdv, t;
   logic [3:0]  pstrb;
   logic        ladder_enable, low_power_side_select, lower_source_select;
   logic [1:0]  upper_source_select;
   logic [4:0]  level_code;
   logic [5:0]  level_tap;
   logic        level_tap_valid, upper_end_connect, lower_end_connect;
   logic        upper_src_supply, upper_src_ext, upper_src_fixed;
   logic        lower_src_ext, lower_src_ground, rerr;
   logic        port_dout, port_oe_n, port_din, level_out_pin_in;
   logic        level_out_pin_out, level_out_pin_oe_n;
   logic        level_out_pin_analog, level_out_pin_detector_en;
   int          fail_count, comparisons, cycles;

   // Main, level, {valid, tap}, {upper end, lower end}
   localparam logic [31:0] LAD_TAB [8] = '{
      32'h80_00_40_03, 32'h80_10_50_03, 32'hC0_1F_5F_03,
      32'h40_1F_60_02, 32'h40_1E_00_02,
      32'h00_00_40_01, 32'h00_01_00_01, 32'h00_1F_00_01
   };

   rrlc_top #(.ADDR_W(8)) rrlc_top_inst (.*);

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] e,
                        input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %0h seen %0h", what, e, g);
      end
   endtask : check

   task automatic bus(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= we;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdv = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : bus

   // Write, then let the control outputs land
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      @(posedge pclk);
      #1;
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                         input logic ee);
      bus(1'b0, a, 32'h0);
      check("ready", 32'h1, 32'(pready));
      check("read data", e, rdv);
      check("read error", 32'(ee), 32'(rerr));
   endtask : rd_chk

   task automatic finish_test();
      $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         finish_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hF;
      presetn = 1'b0;
      {port_dout, port_oe_n, level_out_pin_in} = 3'b101;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(RRLC_OFF_MAIN, 32'h0, 1'b0);
      rd_chk(RRLC_OFF_LEVEL, 32'h0, 1'b0);
      wr(RRLC_OFF_MAIN, 32'hFFFF_FFFF);
      rd_chk(RRLC_OFF_MAIN, 32'hED, 1'b0);
      wr(RRLC_OFF_LEVEL, 32'hFFFF_FFFF);
      rd_chk(RRLC_OFF_LEVEL, 32'h1F, 1'b0);
      for (int u = 0; u < 4; u++) begin
         wr(RRLC_OFF_MAIN, 32'(u * 5));
         check("upper src", u < 3 ? 32'(1 << u) : 32'h0,
               32'({upper_src_fixed, upper_src_ext, upper_src_supply}));
         check("lower src", 32'(1 + u % 2),
               32'({lower_src_ext, lower_src_ground}));
         check("upper sel", 32'(u), 32'(upper_source_select));
         check("lower sel", 32'(u % 2), 32'(lower_source_select));
      end
      // Status ignores writes; reserved upper code flagged
      wr(RRLC_OFF_STATUS, 32'hFFFF_FFFF);
      rd_chk(RRLC_OFF_STATUS, 32'hC, 1'b0);
      for (int i = 0; i < 8; i++) begin
         t = LAD_TAB[i];
         wr(RRLC_OFF_MAIN, 32'(t[31:24]));
         wr(RRLC_OFF_LEVEL, 32'(t[23:16]));
         check("enable", 32'(t[31]), 32'(ladder_enable));
         check("side select", 32'(t[30]), 32'(low_power_side_select));
         check("level code", 32'(t[20:16]), 32'(level_code));
         check("tap", 32'(t[15:8]), 32'({level_tap_valid, level_tap}));
         check("ends", 32'(t[7:0]),
               32'({upper_end_connect, lower_end_connect}));
      end
      wr(RRLC_OFF_MAIN, 32'h20);
      repeat (3) @(posedge pclk);
      check("pin analog", 32'h14, 32'({level_out_pin_analog,
            level_out_pin_out, level_out_pin_oe_n,
            level_out_pin_detector_en, port_din}));
      wr(RRLC_OFF_MAIN, 32'h00);
      repeat (3) @(posedge pclk);
      check("pin digital", 32'hB, 32'({level_out_pin_analog,
            level_out_pin_out, level_out_pin_oe_n,
            level_out_pin_detector_en, port_din}));
      rd_chk(8'h0C, 32'h0, 1'b1);
      wr(8'h0C, 32'hA0);
      @(posedge pclk);
      pstrb <= 4'h0;
      wr(RRLC_OFF_MAIN, 32'hA0);
      @(posedge pclk);
      pstrb <= 4'hF;
      rd_chk(RRLC_OFF_MAIN, 32'h0, 1'b0);
      wr(RRLC_OFF_MAIN, 32'hA5);
      wr(RRLC_OFF_LEVEL, 32'h15);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      check("reset state", 32'h0, 32'({ladder_enable,
            level_out_pin_analog, level_code}));
      rd_chk(RRLC_OFF_MAIN, 32'h0, 1'b0);
      rd_chk(RRLC_OFF_LEVEL, 32'h0, 1'b0);
      // Software turns the reference off before sleep
      wr(RRLC_OFF_MAIN, 32'h80);
      wr(RRLC_OFF_MAIN, 32'h00);
      check("sleep disable", 32'h0, 32'(ladder_enable));
      finish_test();
   end
endmodule : rrlc_top_tb
